// ==== src/tps_cfg_regs.sv ====
`timescale 1ns/1ps
module tps_cfg_regs (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   input wire logic wake_chan_en,
   input wire tps_pkg::tps_mode_e power_mode,
   output logic scan_wake_channel,
   output logic [tps_pkg::TPS_SEL_W-1:0] wake_drive_sel,
   output logic [7:0] conv_fraction,
   output logic [7:0] conv_period_one,
   output logic [7:0] conv_period_two,
   input wire logic conv_start,
   input wire logic conv_tick,
   output logic conv_busy,
   output logic conv_done,
   output logic [tps_pkg::TPS_CNT_W-1:0] conv_count,
   output logic area_filter_en,
   output logic jitter_filter_en,
   output logic fixed_damping_select,
   output logic iir_filter_en,
   input wire logic coord_valid,
   input wire logic [tps_pkg::TPS_COORD_W-1:0] coord_rx,
   input wire logic [tps_pkg::TPS_COORD_W-1:0] coord_tx,
   input wire logic [tps_pkg::TPS_COORD_W-1:0] max_res_x,
   input wire logic [tps_pkg::TPS_COORD_W-1:0] max_res_y,
   output logic pos_valid,
   output logic [tps_pkg::TPS_COORD_W-1:0] pos_x,
   output logic [tps_pkg::TPS_COORD_W-1:0] pos_y
);
   import tps_pkg::*;
   logic [TPS_SEL_W-1:0] wake_sensor_drive_select_r;
   logic [7:0] pad_conv_fraction_r;
   logic [7:0] pad_conv_period_one_r;
   logic [7:0] pad_conv_period_two_r;
   logic [7:0] wake_conv_fraction_r;
   logic [7:0] wake_conv_period_one_r;
   logic [7:0] wake_conv_period_two_r;
   logic [TPS_HW_W-1:0] pad_conv_hw_settings_r;
   logic [TPS_HW_W-1:0] wake_conv_hw_settings_r;
   logic [7:0] pad_position_settings_r;
   logic [7:0] rdata_nxt;
   logic hit_nxt;
   logic sel_hit;
   logic [2:0] sel_idx;
   logic [TPS_HW_W-1:0] active_hw;

   // ==========================================================
   // Address decode for the electrode map, byte 0 at the base
   assign sel_hit = (reg_addr >= TPS_WAKE_SEL_ADDR) && (reg_addr <= TPS_WAKE_SEL_LAST);
   assign sel_idx = 3'(reg_addr - TPS_WAKE_SEL_ADDR);

   // ==========================================================
   // Electrode map writes
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wake_sensor_drive_select_r <= TPS_SEL_RST;
      end else if (reg_wr && sel_hit) begin
         wake_sensor_drive_select_r[sel_idx*8 +: 8] <= reg_wdata;
      end
   end

   // ==========================================================
   // frequency byte registers
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pad_conv_fraction_r <= TPS_BYTE_RST;
         pad_conv_period_one_r <= TPS_BYTE_RST;
         pad_conv_period_two_r <= TPS_BYTE_RST;
         wake_conv_fraction_r <= TPS_BYTE_RST;
         wake_conv_period_one_r <= TPS_BYTE_RST;
         wake_conv_period_two_r <= TPS_BYTE_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            TPS_PAD_FRAC_ADDR: pad_conv_fraction_r <= reg_wdata;
            TPS_PAD_P1_ADDR: pad_conv_period_one_r <= reg_wdata;
            TPS_PAD_P2_ADDR: pad_conv_period_two_r <= reg_wdata;
            TPS_WAKE_FRAC_ADDR: wake_conv_fraction_r <= reg_wdata;
            TPS_WAKE_P1_ADDR: wake_conv_period_one_r <= reg_wdata;
            TPS_WAKE_P2_ADDR: wake_conv_period_two_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // two hardware settings words, low byte first
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pad_conv_hw_settings_r <= TPS_HW_RST;
         wake_conv_hw_settings_r <= TPS_HW_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            TPS_PAD_HW_ADDR: pad_conv_hw_settings_r[7:0] <= reg_wdata;
            TPS_PAD_HW_ADDR + 16'h0001: pad_conv_hw_settings_r[15:8] <= reg_wdata;
            TPS_WAKE_HW_ADDR: wake_conv_hw_settings_r[7:0] <= reg_wdata;
            TPS_WAKE_HW_ADDR + 16'h0001: wake_conv_hw_settings_r[15:8] <= reg_wdata;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Position settings; bit 7 unused and held at zero
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pad_position_settings_r <= TPS_POS_RST;
      end else if (reg_wr && reg_addr == TPS_POS_ADDR) begin
         pad_position_settings_r <= reg_wdata & TPS_POS_MASK;
      end
   end

   // ==========================================================
   // Read back; unmapped addresses read zero with reg_hit low
   always_comb begin
      rdata_nxt = 8'h00;
      hit_nxt = 1'b1;
      if (sel_hit) begin
         rdata_nxt = wake_sensor_drive_select_r[sel_idx*8 +: 8];
      end else begin
         case (reg_addr)
            TPS_PAD_FRAC_ADDR: rdata_nxt = pad_conv_fraction_r;
            TPS_PAD_P1_ADDR: rdata_nxt = pad_conv_period_one_r;
            TPS_PAD_P2_ADDR: rdata_nxt = pad_conv_period_two_r;
            TPS_WAKE_FRAC_ADDR: rdata_nxt = wake_conv_fraction_r;
            TPS_WAKE_P1_ADDR: rdata_nxt = wake_conv_period_one_r;
            TPS_WAKE_P2_ADDR: rdata_nxt = wake_conv_period_two_r;
            TPS_PAD_HW_ADDR: rdata_nxt = pad_conv_hw_settings_r[7:0];
            TPS_PAD_HW_ADDR + 16'h0001: rdata_nxt = pad_conv_hw_settings_r[15:8];
            TPS_WAKE_HW_ADDR: rdata_nxt = wake_conv_hw_settings_r[7:0];
            TPS_WAKE_HW_ADDR + 16'h0001: rdata_nxt = wake_conv_hw_settings_r[15:8];
            TPS_POS_ADDR: rdata_nxt = pad_position_settings_r;
            default: hit_nxt = 1'b0;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
         reg_hit <= 1'b0;
      end else if (reg_rd) begin
         reg_rdata <= rdata_nxt;
         reg_hit <= hit_nxt;
      end
   end

   // ==========================================================
   // Wake-up sensor selection, registered toward the sequencer
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         scan_wake_channel <= 1'b0;
         wake_drive_sel <= '0;
      end else begin
         scan_wake_channel <= wake_chan_en && (power_mode == TPS_MODE_LP_ONE ||
                                               power_mode == TPS_MODE_LP_TWO);
         wake_drive_sel <= wake_chan_en ? (wake_sensor_drive_select_r & TPS_SEL_VALID) : '0;
      end
   end

   // ==========================================================
   // Frequency set of whichever channel is scanned
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         conv_fraction <= 8'h00;
         conv_period_one <= 8'h00;
         conv_period_two <= 8'h00;
      end else if (scan_wake_channel) begin
         conv_fraction <= wake_conv_fraction_r;
         conv_period_one <= wake_conv_period_one_r;
         conv_period_two <= wake_conv_period_two_r;
      end else begin
         conv_fraction <= pad_conv_fraction_r;
         conv_period_one <= pad_conv_period_one_r;
         conv_period_two <= pad_conv_period_two_r;
      end
   end

   // ==========================================================
   // Conversion hardware settings follow the scanned channel
   assign active_hw = scan_wake_channel ? wake_conv_hw_settings_r : pad_conv_hw_settings_r;

   tps_conv_seq u_seq (
      .mclk(mclk),
      .nrst(nrst),
      .start(conv_start),
      .tick(conv_tick),
      .hw(active_hw),
      .busy(conv_busy),
      .done(conv_done),
      .count(conv_count)
   );

   // ==========================================================
   // Filter controls to the coordinate pipeline
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         area_filter_en <= 1'b1;
         jitter_filter_en <= 1'b0;
         fixed_damping_select <= 1'b0;
         iir_filter_en <= 1'b0;
      end else begin
         area_filter_en <= !pad_position_settings_r[TPS_POS_AREA_DIS];
         jitter_filter_en <= pad_position_settings_r[TPS_POS_JITTER];
         fixed_damping_select <= pad_position_settings_r[TPS_POS_FIXED_DAMP];
         iir_filter_en <= pad_position_settings_r[TPS_POS_IIR];
      end
   end

   // ==========================================================
   // Orientation stage
   tps_coord_map u_map (
      .mclk(mclk),
      .nrst(nrst),
      .in_valid(coord_valid),
      .raw_rx(coord_rx),
      .raw_tx(coord_tx),
      .max_x(max_res_x),
      .max_y(max_res_y),
      .swap(pad_position_settings_r[TPS_POS_SWAP]),
      .flip_x(pad_position_settings_r[TPS_POS_FLIP_X]),
      .flip_y(pad_position_settings_r[TPS_POS_FLIP_Y]),
      .out_valid(pos_valid),
      .pos_x(pos_x),
      .pos_y(pos_y)
   );
endmodule : tps_cfg_regs

// ==== include/tps_pkg.sv ====
package tps_pkg;
   // ==========================================================
   // Register byte addresses
   localparam logic [15:0] TPS_WAKE_SEL_ADDR = 16'h11C6;
   localparam logic [15:0] TPS_WAKE_SEL_LAST = 16'h11CB;
   localparam logic [15:0] TPS_PAD_FRAC_ADDR = 16'h11D8;
   localparam logic [15:0] TPS_PAD_P1_ADDR = 16'h11D9;
   localparam logic [15:0] TPS_PAD_P2_ADDR = 16'h11DA;
   localparam logic [15:0] TPS_WAKE_FRAC_ADDR = 16'h11DB;
   localparam logic [15:0] TPS_WAKE_P1_ADDR = 16'h11DC;
   localparam logic [15:0] TPS_WAKE_P2_ADDR = 16'h11DD;
   localparam logic [15:0] TPS_PAD_HW_ADDR = 16'h11DE;
   localparam logic [15:0] TPS_WAKE_HW_ADDR = 16'h11E0;
   localparam logic [15:0] TPS_POS_ADDR = 16'h11E2;
   // ==========================================================
   // Widths and reset values
   localparam int TPS_SEL_W = 48;
   localparam int TPS_SEL_BYTES = 6;
   localparam int TPS_HW_W = 16;
   localparam int TPS_CNT_W = 12;
   localparam int TPS_COORD_W = 16;
   localparam logic [47:0] TPS_SEL_RST = 48'h0;
   // Bit 44 is reserved and bits 47-46 unused; they never select anything
   localparam logic [47:0] TPS_SEL_VALID = 48'h2FFF_FFFF_FFFF;
   localparam logic [7:0] TPS_BYTE_RST = 8'h00;
   localparam logic [15:0] TPS_HW_RST = 16'h0000;
   localparam logic [7:0] TPS_POS_RST = 8'h00;
   localparam logic [7:0] TPS_POS_MASK = 8'h7F;
   // ==========================================================
   // Field positions
   localparam int TPS_HW_DLY_HI = 15;
   localparam int TPS_HW_DLY_LO = 14;
   localparam int TPS_HW_LIM_HI = 10;
   localparam int TPS_HW_LIM_LO = 8;
   localparam int TPS_POS_AREA_DIS = 6;
   localparam int TPS_POS_JITTER = 5;
   localparam int TPS_POS_FIXED_DAMP = 4;
   localparam int TPS_POS_IIR = 3;
   localparam int TPS_POS_SWAP = 2;
   localparam int TPS_POS_FLIP_Y = 1;
   localparam int TPS_POS_FLIP_X = 0;
   // ==========================================================
   // Power mode codes: active and two low-power modes
   typedef enum logic [1:0] {
      TPS_MODE_ACTIVE = 2'h0,
      TPS_MODE_LP_ONE = 2'h1,
      TPS_MODE_LP_TWO = 2'h2
   } tps_mode_e;
   // Conversion sequencer states, Gray along idle-delay-convert-done
   typedef enum logic [1:0] {
      TPS_IDLE = 2'h0,
      TPS_DELAY = 2'h1,
      TPS_CONV = 2'h3,
      TPS_DONE = 2'h2
   } tps_state_e;
   // ==========================================================
   // Decoders
   function automatic logic [TPS_CNT_W-1:0] tps_delay(input logic [1:0] code);
      unique case (code)
         2'h0: tps_delay = 12'h010;
         2'h1: tps_delay = 12'h020;
         2'h2: tps_delay = 12'h040;
         2'h3: tps_delay = 12'h100;
      endcase
   endfunction : tps_delay
   // Undefined codes from 100 upward fall back to the longest limit
   function automatic logic [TPS_CNT_W-1:0] tps_limit(input logic [2:0] code);
      case (code)
         3'h0: tps_limit = 12'h17F;
         3'h1: tps_limit = 12'h1FF;
         3'h2: tps_limit = 12'h2FF;
         3'h3: tps_limit = 12'h3FF;
         default: tps_limit = 12'h7FF;
      endcase
   endfunction : tps_limit
endpackage : tps_pkg

// ==== src/tps_conv_seq.sv ====
`timescale 1ns/1ps
module tps_conv_seq (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic start,
   input wire logic tick,
   input wire logic [tps_pkg::TPS_HW_W-1:0] hw,
   output logic busy,
   output logic done,
   output logic [tps_pkg::TPS_CNT_W-1:0] count
);
   import tps_pkg::*;
   tps_state_e state_r;
   logic [TPS_CNT_W-1:0] cnt_r;
   logic [TPS_CNT_W-1:0] dly_r;
   logic [TPS_CNT_W-1:0] lim_r;
   // ==========================================================
   // Sequencer; settings latched at start so a mid-run write is safe
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state_r <= TPS_IDLE;
         cnt_r <= '0;
         dly_r <= '0;
         lim_r <= '0;
      end else begin
         unique case (state_r)
            TPS_IDLE: if (start) begin
               dly_r <= tps_delay(hw[TPS_HW_DLY_HI:TPS_HW_DLY_LO]);
               lim_r <= tps_limit(hw[TPS_HW_LIM_HI:TPS_HW_LIM_LO]);
               cnt_r <= '0;
               state_r <= TPS_DELAY;
            end
            TPS_DELAY: if (tick) begin
               if (cnt_r == dly_r - 12'h001) begin
                  cnt_r <= '0;
                  state_r <= TPS_CONV;
               end else begin
                  cnt_r <= cnt_r + 12'h001;
               end
            end
            TPS_CONV: begin
               if (cnt_r == lim_r) begin
                  state_r <= TPS_DONE;
               end else if (tick) begin
                  cnt_r <= cnt_r + 12'h001;
               end
            end
            TPS_DONE: state_r <= TPS_IDLE;
         endcase
      end
   end
   assign busy = (state_r != TPS_IDLE);
   assign done = (state_r == TPS_DONE);
   assign count = cnt_r;
endmodule : tps_conv_seq

// ==== src/tps_coord_map.sv ====
`timescale 1ns/1ps
module tps_coord_map (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic in_valid,
   input wire logic [tps_pkg::TPS_COORD_W-1:0] raw_rx,
   input wire logic [tps_pkg::TPS_COORD_W-1:0] raw_tx,
   input wire logic [tps_pkg::TPS_COORD_W-1:0] max_x,
   input wire logic [tps_pkg::TPS_COORD_W-1:0] max_y,
   input wire logic swap,
   input wire logic flip_x,
   input wire logic flip_y,
   output logic out_valid,
   output logic [tps_pkg::TPS_COORD_W-1:0] pos_x,
   output logic [tps_pkg::TPS_COORD_W-1:0] pos_y
);
   import tps_pkg::*;
   logic [TPS_COORD_W-1:0] ax;
   logic [TPS_COORD_W-1:0] ay;
   // ==========================================================
   // axis roles
   assign ax = swap ? raw_tx : raw_rx;
   assign ay = swap ? raw_rx : raw_tx;
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         out_valid <= 1'b0;
         pos_x <= '0;
         pos_y <= '0;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            pos_x <= flip_x ? max_x - ax : ax;
            pos_y <= flip_y ? max_y - ay : ay;
         end
      end
   end
endmodule : tps_coord_map

// ==== dv/tps_cfg_regs_assertions.sv ====
`timescale 1ns/1ps
module tps_cfg_regs_chk (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_hit,
   input wire logic wake_chan_en,
   input wire tps_pkg::tps_mode_e power_mode,
   input wire logic scan_wake_channel,
   input wire logic [tps_pkg::TPS_SEL_W-1:0] wake_drive_sel,
   input wire logic conv_start,
   input wire logic conv_busy,
   input wire logic conv_done,
   input wire logic [tps_pkg::TPS_CNT_W-1:0] conv_count,
   input wire logic area_filter_en,
   input wire logic jitter_filter_en,
   input wire logic fixed_damping_select,
   input wire logic iir_filter_en,
   input wire logic coord_valid,
   input wire logic pos_valid
);
   import tps_pkg::*;
   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence pos_wr_s;
      reg_wr && reg_addr == TPS_POS_ADDR;
   endsequence
   unmapped_rd_a:
      assert property (reg_rd && reg_addr == 16'h11D0 |=> !reg_hit && reg_rdata == 8'h00)
      else $error("unmapped read answered");
   scan_select_a:
      assert property ($past(nrst) |-> scan_wake_channel == ($past(wake_chan_en) &&
         $past(power_mode) inside {TPS_MODE_LP_ONE, TPS_MODE_LP_TWO}))
      else $error("wake scan select wrong");
   sel_gated_a:
      assert property ($past(nrst) && !$past(wake_chan_en) |-> wake_drive_sel == '0)
      else $error("drive select live while wake channel off");
   sel_mask_a:
      assert property ((wake_drive_sel & ~TPS_SEL_VALID) == '0)
      else $error("reserved drive select bit active");
   start_busy_a:
      assert property (conv_start && !conv_busy |=> conv_busy && conv_count == '0)
      else $error("start not taken");
   done_idle_a:
      assert property (conv_done |=> !conv_done && !conv_busy)
      else $error("done not a single pulse before idle");
   done_limit_a:
      assert property ($rose(conv_done) |->
         conv_count inside {12'h17F, 12'h1FF, 12'h2FF, 12'h3FF, 12'h7FF})
      else $error("conversion stopped off a limit");
   filter_bits_a:
      assert property (pos_wr_s ##1 !pos_wr_s |=>
         {area_filter_en, jitter_filter_en, fixed_damping_select, iir_filter_en} ==
         {~$past(reg_wdata[6], 2), $past(reg_wdata[5], 2), $past(reg_wdata[4], 2),
         $past(reg_wdata[3], 2)})
      else $error("filter controls do not follow settings");
   pos_pulse_a:
      assert property ($past(nrst) |-> pos_valid == $past(coord_valid))
      else $error("position valid not one cycle after input");
   cover property (conv_done);
   cover property (pos_valid);
   cover property (scan_wake_channel);
endmodule : tps_cfg_regs_chk

bind tps_cfg_regs tps_cfg_regs_chk tps_cfg_regs_chk_inst (.mclk, .nrst, .reg_addr, .reg_wr,
   .reg_wdata, .reg_rd, .reg_rdata, .reg_hit, .wake_chan_en, .power_mode, .scan_wake_channel,
   .wake_drive_sel, .conv_start, .conv_busy, .conv_done, .conv_count, .area_filter_en,
   .jitter_filter_en, .fixed_damping_select, .iir_filter_en, .coord_valid, .pos_valid);

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
   import tps_pkg::*;
   logic mclk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, wake_chan_en = 1'h0;
   logic conv_start = 1'h0, conv_tick = 1'h0, coord_valid = 1'h0, s;
   logic [15:0] reg_addr = 16'h0000, coord_rx = 16'h0000, coord_tx = 16'h0456;
   logic [15:0] max_res_x = 16'h1000, max_res_y = 16'h0800, pos_x, pos_y;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, conv_fraction, conv_period_one, conv_period_two;
   logic reg_hit, scan_wake_channel, conv_busy, conv_done, pos_valid;
   logic area_filter_en, jitter_filter_en, fixed_damping_select, iir_filter_en;
   logic [47:0] wake_drive_sel;
   logic [11:0] conv_count;
   tps_mode_e power_mode = TPS_MODE_ACTIVE;
   int bad_count = 0, num_checks = 0, cyc = 0;
   logic [11:0] lim_tab [5] = '{12'h17F, 12'h1FF, 12'h2FF, 12'h3FF, 12'h7FF};

   always #10 mclk = ~mclk;

   tps_cfg_regs tps_cfg_regs_inst (.mclk, .nrst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
      .reg_rdata, .reg_hit, .wake_chan_en, .power_mode, .scan_wake_channel, .wake_drive_sel,
      .conv_fraction, .conv_period_one, .conv_period_two, .conv_start, .conv_tick, .conv_busy,
      .conv_done, .conv_count, .area_filter_en, .jitter_filter_en, .fixed_damping_select,
      .iir_filter_en, .coord_valid, .coord_rx, .coord_tx, .max_res_x, .max_res_y, .pos_valid,
      .pos_x, .pos_y);

   // ==========================================================
   // Access tasks
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   function automatic logic mapped(input logic [15:0] a);
      return a <= 16'h11CB || a >= 16'h11D8;
   endfunction : mapped

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge mclk);
      reg_wr <= 1'h0;
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic h);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge mclk);
      reg_rd <= 1'h0;
      #1;
      chk("rdata", 48'(e), 48'(reg_rdata));
      chk("hit", 48'(h), 48'(reg_hit));
   endtask : rd

   // Raw rx carries the settings byte so every swap and flip case sees distinct data
   task automatic coord(input logic [7:0] p);
      logic [15:0] x, y;
      x = p[2] ? 16'h0456 : {8'h01, p};
      y = p[2] ? {8'h01, p} : 16'h0456;
      if (p[0]) x = 16'h1000 - x;
      if (p[1]) y = 16'h0800 - y;
      @(posedge mclk);
      coord_valid <= 1'h1;
      coord_rx <= {8'h01, p};
      @(posedge mclk);
      coord_valid <= 1'h0;
      #1;
      chk("pos_valid", 48'h1, 48'(pos_valid));
      chk("pos_x", 48'(x), 48'(pos_x));
      chk("pos_y", 48'(y), 48'(pos_y));
      chk("filters", 48'({~p[6], p[5:3]}), 48'({area_filter_en, jitter_filter_en,
         fixed_damping_select, iir_filter_en}));
   endtask : coord

   // A start pulse mid-run must be ignored, else the span grows past its bound
   task automatic run(input int d, input logic [11:0] l);
      int n;
      n = 0;
      @(posedge mclk);
      conv_start <= 1'h1;
      @(posedge mclk);
      conv_start <= 1'h0;
      while (n < 3000) begin
         @(posedge mclk);
         conv_start <= (n == 4);
         #1;
         n++;
         if (conv_done === 1'h1) break;
      end
      chk("span_lo", 48'h1, 48'(n >= d + l));
      chk("span_hi", 48'h1, 48'(n <= d + l + 3));
      chk("count", 48'(l), 48'(conv_count));
      @(posedge mclk);
      #1;
      chk("idle", 48'h0, 48'(conv_busy));
   endtask : run

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         wrap_up();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge mclk);
      nrst <= 1'h1;
      conv_tick <= 1'h1;
      #1;
      chk("area_rst", 48'h1, 48'(area_filter_en));
      for (logic [15:0] a = 16'h11C6; a <= 16'h11E2; a++) rd(a, 8'h00, mapped(a));
      for (logic [15:0] a = 16'h11C6; a <= 16'h11E2; a++) wr(a, a[7:0] ^ 8'h5A);
      for (logic [15:0] a = 16'h11C6; a <= 16'h11E2; a++) rd(a, mapped(a) ? (a[7:0] ^ 8'h5A)
         & (a == TPS_POS_ADDR ? 8'h7F : 8'hFF) : 8'h00, mapped(a));
      for (int m = 0; m < 3; m++) begin
         for (int e = 0; e < 2; e++) begin
            @(posedge mclk);
            power_mode <= tps_mode_e'(m);
            wake_chan_en <= e[0];
            repeat (3) @(posedge mclk);
            #1;
            s = e[0] && m != 0;
            chk("scan", 48'(s), 48'(scan_wake_channel));
            chk("sel", e[0] ? 48'h9190_9392_9D9C & TPS_SEL_VALID : 48'h0,
               wake_drive_sel);
            chk("conv", s ? 48'h81_8687 : 48'h82_8380,
               48'({conv_fraction, conv_period_one, conv_period_two}));
         end
      end
      // Small-variant map: electrodes 13 to 32 kept deselected by the host
      wr(16'h11C7, 8'h1F);
      wr(16'h11C8, 8'h00);
      wr(16'h11C9, 8'h00);
      wr(16'h11CA, 8'hFE);
      repeat (2) @(posedge mclk);
      #1;
      chk("sel_small", 48'h01FE_0000_1F9C, wake_drive_sel);
      @(posedge mclk);
      wake_chan_en <= 1'h0;
      // Legal frequency set for 1.00 MHz: fraction 16, periods 7 and 7
      wr(TPS_PAD_FRAC_ADDR, 8'h10);
      wr(TPS_PAD_P1_ADDR, 8'h07);
      wr(TPS_PAD_P2_ADDR, 8'h07);
      repeat (2) @(posedge mclk);
      #1;
      chk("conv_1mhz", 48'h10_0707,
         48'({conv_fraction, conv_period_one, conv_period_two}));
      for (int k = 0; k < 16; k++) begin
         wr(TPS_POS_ADDR, {1'h1, 4'(k), 3'(k)});
         coord({1'h1, 4'(k), 3'(k)});
         rd(TPS_POS_ADDR, {1'h0, 4'(k), 3'(k)}, 1'h1);
      end
      @(posedge mclk);
      wake_chan_en <= 1'h0;
      for (int i = 0; i < 5; i++) begin
         wr(16'h11DF, {2'(i), 3'h0, 3'(i)});
         run((i % 4 == 3) ? 256 : 16 << (i % 4), lim_tab[i]);
      end
      @(posedge mclk);
      wake_chan_en <= 1'h1;
      power_mode <= TPS_MODE_LP_TWO;
      wr(16'h11E1, 8'h47);
      run(32, 12'h7FF);
      wrap_up();
   end
endmodule : tb
